// >>> sac_core.sv
// sar converter digital control: framed serial readout and offset calibration
`timescale 1ns/1ps
// Function
// - each select-low period after the first is one conversion and transfer frame.
// - select falling captures the differential sample; inputs stay disconnected while converting.
// - host serial clock alone steps conversion and shifting.
// - first bit on select fall, then a zero, then twelve result bits.
// - after fourteen clocks, data output held low while selected.
// - select rising ends the frame and floats the data output.
// - on conversion completion reconnect sampling capacitors and acquire.
// - results are twelve-bit two's complement.
// - 800 negative full scale, 000 mid, 7FF positive full scale.
// - sixteen megahertz serial clock gives one frame per microsecond.
// - calibration starts on first select fall after power-up; inputs disconnected.
// - data output held low for the whole first frame.
// - after first frame, offset calibrated or not by its clock count.
// - host may trigger calibration during normal operation.
// - offset store is not reachable through the serial interface.
// - offset store clears to zero at power-up.
// - only power cycling resets calibration; no serial command does.
// - power-up calibration completes only with at least sixteen clocks; otherwise store unchanged.
// - long frames calibrate from edge seventeen to thirty-two; shorter leave store.
// - later samples are corrected by the offset store before shifting.
module sac_core
   import sac_pkg::*;
#(
   parameter int RES = SAC_RES,
   parameter int FIFO_DEPTH = SAC_FIFO_DEPTH
) (
   // clock and power-up reset
   input wire logic clk,
   input wire logic reset,
   // serial link pins from host
   input wire logic select_n,
   input wire logic sclk,
   // serial data pin (three-state)
   output logic sdo_out,
   output logic sdo_oe,
   // sar comparator front end
   input wire logic [RES-1:0] raw_code,
   input wire logic [RES-1:0] raw_offset,
   output logic sample_hold,
   output logic inputs_connected,
   output logic cal_active,
   // status
   output logic offset_calibrated,
   output logic overflow
);
   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_FRAME
   } sac_state_e;
   typedef struct packed {
      sac_state_e state;
      logic cs_q;
      logic sck_q;
      logic first_frame;
      logic [5:0] edges;
      logic [RES+1:0] shreg;
      logic sdo;
      logic oe;
      logic converting;
      logic calibrating;
      logic [RES-1:0] offset;
      logic calibrated;
      logic ovf;
      logic load_pend;
   } sac_core_s;
   sac_core_s st_r;
   sac_core_s st_nxt;
   logic cs_s;
   logic sck_s;
   logic cs_fall;
   logic cs_rise;
   logic sck_fall;
   logic [RES-1:0] corrected;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [RES-1:0] fifo_out_data;
   logic [RES+1:0] shsrc;
   logic tail_edge;
   logic data_last_edge;
   logic pwr_cal_edge;
   logic cal_start_edge;
   logic cal_done_edge;
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   sac_sync #(.INIT(1'b1)) u_cs_sync (
      .clk(clk),
      .reset(reset),
      .din(select_n),
      .dout(cs_s)
   );
   // the serial clock is sampled, so each half period must span at least three clk cycles
   sac_sync #(.INIT(1'b0)) u_sck_sync (
      .clk(clk),
      .reset(reset),
      .din(sclk),
      .dout(sck_s)
   );
   assign cs_fall = st_r.cs_q && !cs_s;
   assign cs_rise = !st_r.cs_q && cs_s;
   // serial clock edges only count inside a frame
   assign sck_fall = st_r.sck_q && !sck_s && !cs_s;
   // ---------------------------------------------------------------
   // edge decode; edges holds the count of falls before this one
   // ---------------------------------------------------------------
   assign tail_edge = st_r.first_frame || (st_r.edges >= (SAC_DATA_EDGES - 6'd1));
   assign data_last_edge = !st_r.first_frame &&
                           (st_r.edges == (SAC_DATA_EDGES - 6'd1));
   assign pwr_cal_edge = st_r.first_frame &&
                         (st_r.edges == (SAC_PWRUP_CAL_EDGES - 6'd1));
   assign cal_start_edge = !st_r.first_frame &&
                           (st_r.edges == (SAC_CAL_START_EDGE - 6'd1));
   assign cal_done_edge = !st_r.first_frame &&
                          (st_r.edges == (SAC_CAL_DONE_EDGE - 6'd1));
   // ---------------------------------------------------------------
   // offset correction and sample buffer
   // ---------------------------------------------------------------
   // two's complement subtraction wraps; saturation keeps the code inside full scale
   function automatic logic [RES-1:0] sac_correct(input logic [RES-1:0] code,
                                                  input logic [RES-1:0] ofs);
      logic [RES:0] diff;
      diff = {code[RES-1], code} - {ofs[RES-1], ofs};
      if (diff[RES] != diff[RES-1]) begin
         sac_correct = diff[RES] ? SAC_NEG_FULL_SCALE_CODE : SAC_POS_FULL_SCALE_CODE;
      end else begin
         sac_correct = diff[RES-1:0];
      end
   endfunction
   assign corrected = sac_correct(raw_code, st_r.offset);
   // the sample is captured into the buffer at select fall; the shifter drains it
   assign fifo_in_valid = cs_fall && !st_r.first_frame;
   // the word pushed at select fall is popped on the next cycle, so the buffer never lags
   assign fifo_out_ready = st_r.load_pend && fifo_out_valid;
   // a fall in the same cycle as the pop shifts the fresh word, not the stale register
   assign shsrc = st_r.load_pend ? {2'b00, fifo_out_data} : st_r.shreg;
   sac_fifo #(.WIDTH(RES), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(corrected),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .flush(1'b0)
   );
   // ---------------------------------------------------------------
   // frame sequencer
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.cs_q = cs_s;
      st_nxt.sck_q = sck_s;
      unique case (st_r.state)
         SAC_IDLE: begin
            st_nxt.oe = 1'b0;
            if (cs_fall) begin
               st_nxt.state = SAC_FRAME;
               st_nxt.edges = '0;
               st_nxt.oe = 1'b1;
               if (st_r.first_frame) begin
                  st_nxt.calibrating = 1'b1;
                  st_nxt.shreg = '0;
                  st_nxt.converting = 1'b0;
               end else begin
                  st_nxt.converting = 1'b1;
                  st_nxt.load_pend = 1'b1;
                  if (!fifo_in_ready) begin
                     st_nxt.ovf = 1'b1;
                  end
               end
               st_nxt.sdo = 1'b0;
            end
         end
         SAC_FRAME: begin
            st_nxt.load_pend = 1'b0;
            st_nxt.shreg = shsrc;
            if (cs_rise) begin
               st_nxt.state = SAC_IDLE;
               st_nxt.oe = 1'b0;
               st_nxt.sdo = 1'b0;
               st_nxt.converting = 1'b0;
               st_nxt.calibrating = 1'b0;
               if (st_r.first_frame) begin
                  st_nxt.first_frame = 1'b0;
               end
            end else if (sck_fall) begin
               if (st_r.edges != SAC_EDGE_MAX) begin
                  // frame length counts serial clocks only; throughput follows the host rate
                  st_nxt.edges = 6'(st_r.edges + 1'b1);
               end
               st_nxt.shreg = {shsrc[RES:0], 1'b0};
               if (tail_edge) begin
                  st_nxt.sdo = 1'b0;
               end else begin
                  st_nxt.sdo = shsrc[RES];
               end
               if (data_last_edge) begin
                  st_nxt.converting = 1'b0;
               end
               if (pwr_cal_edge) begin
                  st_nxt.offset = raw_offset;
                  st_nxt.calibrated = 1'b1;
                  st_nxt.calibrating = 1'b0;
               end
               if (cal_start_edge) begin
                  st_nxt.calibrating = 1'b1;
               end
               if (cal_done_edge) begin
                  st_nxt.offset = raw_offset;
                  st_nxt.calibrated = 1'b1;
                  st_nxt.calibrating = 1'b0;
               end
            end
         end
         default: begin
            st_nxt.state = SAC_IDLE;
         end
      endcase
   end
   // ---------------------------------------------------------------
   // state register; only power-up reset clears calibration
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st_r.state <= SAC_IDLE;
         st_r.cs_q <= 1'b1;
         st_r.sck_q <= 1'b0;
         st_r.first_frame <= 1'b1;
         st_r.edges <= '0;
         st_r.shreg <= '0;
         st_r.sdo <= 1'b0;
         st_r.oe <= 1'b0;
         st_r.converting <= 1'b0;
         st_r.calibrating <= 1'b0;
         st_r.offset <= SAC_OFFSET_RESET;
         st_r.calibrated <= 1'b0;
         st_r.ovf <= 1'b0;
         st_r.load_pend <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end
   // ---------------------------------------------------------------
   // outputs; offset store has no serial path
   // ---------------------------------------------------------------
   assign sdo_out = st_r.sdo;
   assign sdo_oe = st_r.oe;
   assign sample_hold = st_r.converting;
   assign inputs_connected = !st_r.converting && !st_r.calibrating;
   assign cal_active = st_r.calibrating;
   assign offset_calibrated = st_r.calibrated;
   assign overflow = st_r.ovf;
endmodule

// >>> sac_core_monitor.sv
// port checks for sac_core
`timescale 1ns/1ps
module sac_core_monitor (
   // clock
   input wire logic clk,
   input wire logic reset,
   // pins
   input wire logic select_n,
   input wire logic sclk,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   // status
   input wire logic sample_hold,
   input wire logic inputs_connected,
   input wire logic cal_active,
   input wire logic offset_calibrated
);
   logic sq_r;
   logic low_r;
   logic first_r;
   logic [5:0] fc_r;
   // ---------------------------------------------------------------
   // serial clock falls in this frame, first frame after reset
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      sq_r <= sclk;
      if (reset || select_n) begin
         fc_r <= 6'h00;
      end else if (sq_r && !sclk && fc_r != 6'h3F) begin
         fc_r <= fc_r + 6'h01;
      end
      if (reset) begin
         low_r <= 1'b0;
         first_r <= 1'b1;
      end else begin
         low_r <= low_r | !select_n;
         first_r <= first_r & !(low_r & select_n);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_off; select_n [*7] |-> !sdo_oe; endproperty
   a_off: assert property (p_off) else $error("drive while idle");
   property p_on; (!select_n) [*7] |-> sdo_oe; endproperty
   a_on: assert property (p_on) else $error("no drive in frame");
   property p_first; first_r |-> !sdo_out; endproperty
   a_first: assert property (p_first) else $error("data in first frame");
   property p_tail; sdo_oe && fc_r > 6'h0E |-> !sdo_out; endproperty
   a_tail: assert property (p_tail) else $error("tail not low");
   property p_cal; $rose(cal_active) && !first_r |-> fc_r == 6'h11; endproperty
   a_cal: assert property (p_cal) else $error("cal start edge");
   property p_iso; sample_hold || cal_active |-> !inputs_connected; endproperty
   a_iso: assert property (p_iso) else $error("inputs connected");
   property p_acq; $fell(sample_hold) && !cal_active |-> ##[0:1] inputs_connected; endproperty
   a_acq: assert property (p_acq) else $error("no acquisition");
   property p_conv; $fell(select_n) && !first_r |-> ##[1:6] sample_hold; endproperty
   a_conv: assert property (p_conv) else $error("no conversion");
   property p_load; $rose(offset_calibrated) |-> fc_r >= 6'h10; endproperty
   a_load: assert property (p_load) else $error("early offset load");
endmodule
bind sac_core sac_core_monitor sac_core_monitor_inst (.clk, .reset, .select_n, .sclk,
   .sdo_out, .sdo_oe, .sample_hold, .inputs_connected, .cal_active, .offset_calibrated);

// >>> sac_core_tb.sv
// self-checking bench for sac_core
`timescale 1ns/1ps
module sac_core_tb;
   import sac_pkg::*;
   typedef struct packed {
      logic [11:0] code;
      logic [11:0] ofs;
      logic [5:0] n;
      logic [13:0] exp;
      logic cal;
   } sac_row_s;
   // first row is the power-up calibration frame, then store is 005, later 003
   localparam sac_row_s ROWS [8] = '{
      '{12'h0123, 12'h0005, 6'h10, 14'h0000, 1'b1},
      '{12'h0100, 12'h0005, 6'h0E, 14'h00FB, 1'b1},
      '{12'h0800, 12'h0005, 6'h0E, 14'h0800, 1'b1},
      '{12'h07FF, 12'h0005, 6'h0E, 14'h07FA, 1'b1},
      '{12'h0000, 12'h0005, 6'h0E, 14'h0FFB, 1'b1},
      '{12'h0010, 12'h0003, 6'h20, 14'h000B, 1'b1},
      '{12'h0010, 12'h0007, 6'h14, 14'h000D, 1'b1},
      '{12'h0005, 12'h0007, 6'h0E, 14'h0002, 1'b1}};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] raw_code = 12'h0000;
   logic [11:0] raw_offset = 12'h0000;
   logic select_n, sclk, sdo_out, sdo_oe, sample_hold, inputs_connected, cal_active;
   logic offset_calibrated, overflow;
   logic [13:0] rx;
   int errors = 0;
   int total_checks = 0;
   sac_core sac_core_inst (.clk, .reset, .select_n, .sclk, .sdo_out, .sdo_oe, .raw_code,
      .raw_offset, .sample_hold, .inputs_connected, .cal_active, .offset_calibrated,
      .overflow);
   sac_host sac_host_inst (.clk, .select_n, .sclk, .sdo_out, .sdo_oe);
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({13'h0000, got}, {13'h0000, exp});
   endtask
   task automatic run(input logic [11:0] c, input logic [11:0] o, input int n);
      @(posedge clk);
      raw_code <= c;
      raw_offset <= o;
      sac_host_inst.frame(n, rx);
   endtask
   task automatic do_reset;
      @(posedge clk);
      reset <= 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic final_report;
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report;
   end
   initial begin
      do_reset;
      chk_bit(offset_calibrated, 1'b0);
      foreach (ROWS[i]) begin
         run(ROWS[i].code, ROWS[i].ofs, int'(ROWS[i].n));
         chk(rx, ROWS[i].exp);
         chk_bit(offset_calibrated, ROWS[i].cal);
         chk_bit(sdo_oe, 1'b0);
      end
      // a short first frame after a second power-up leaves the store empty
      do_reset;
      chk_bit(offset_calibrated, 1'b0);
      run(12'h0123, 12'h0055, 8);
      chk(rx, 14'h0000);
      run(12'h0123, 12'h0055, 31);
      chk(rx, 14'h0123);
      chk_bit(offset_calibrated, 1'b0);
      run(12'h0030, 12'h0011, 32);
      chk(rx, 14'h0030);
      chk_bit(offset_calibrated, 1'b1);
      run(12'h0030, 12'h0011, 14);
      chk(rx, 14'h001F);
      // more frames than buffer words wrap its pointers; every result must stay current
      for (int i = 1; i <= 18; i++) begin
         run(12'(i * 3), 12'h0011, 14);
         chk(rx, {2'b00, 12'(12'(i * 3) - 12'h0011)});
         chk_bit(inputs_connected, 1'b1);
      end
      chk_bit(overflow, 1'b0);
      final_report;
   end
endmodule

// >>> sac_fifo.sv
// parameterised fifo between sample capture and serial shifter
`timescale 1ns/1ps
module sac_fifo
   import sac_pkg::*;
#(
   parameter int WIDTH = SAC_RES,
   parameter int DEPTH = SAC_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // flush
   input wire logic flush
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } sac_fifo_s;
   sac_fifo_s st_r;
   sac_fifo_s st_nxt;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic push;
   logic pop;
   assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data = mem_r[st_r.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      st_nxt = st_r;
      if (flush) begin
         st_nxt = '0;
      end else begin
         if (push) begin
            st_nxt.wp = AW'(st_r.wp + 1'b1);
         end
         if (pop) begin
            st_nxt.rp = AW'(st_r.rp + 1'b1);
         end
         if (push && !pop) begin
            st_nxt.cnt = (AW+1)'(st_r.cnt + 1'b1);
         end else if (pop && !push) begin
            st_nxt.cnt = (AW+1)'(st_r.cnt - 1'b1);
         end
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
      if (push && !flush) begin
         mem_r[st_r.wp] <= in_data;
      end
   end
endmodule

// >>> sac_host.sv
// host model: frames select and serial clock, captures serial data
`timescale 1ns/1ps
module sac_host (
   // clock
   input wire logic clk,
   // pins
   output logic select_n,
   output logic sclk,
   input wire logic sdo_out,
   input wire logic sdo_oe
);
   logic last = 1'b0;
   logic sdo_w;
   // a floating line shows the inverse of its last level, never a kind value
   assign sdo_w = sdo_oe ? sdo_out : ~last;
   always @(posedge clk) if (sdo_oe) last <= sdo_out;
   // clock stands still high between frames
   initial begin
      select_n = 1'b1;
      sclk = 1'b1;
   end
   task automatic frame(input int n, output logic [13:0] rx);
      rx = 14'h0000;
      @(posedge clk);
      select_n <= 1'b0;
      repeat (8) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         if (i < 14) rx = {rx[12:0], sdo_w};
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
      end
      select_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask
endmodule

// >>> sac_pkg.sv
// package: shared constants for the sar converter serial readout and offset calibration
package sac_pkg;
   // ---------------------------------------------------------------
   // code format
   // ---------------------------------------------------------------
   localparam int SAC_RES = 12;
   localparam logic [11:0] SAC_NEG_FULL_SCALE_CODE = 12'h0800;
   localparam logic [11:0] SAC_MID_SCALE_CODE = 12'h0000;
   localparam logic [11:0] SAC_POS_FULL_SCALE_CODE = 12'h07FF;
   localparam logic [11:0] SAC_OFFSET_RESET = 12'h0000;
   // ---------------------------------------------------------------
   // frame timing in serial clock falling edges
   // ---------------------------------------------------------------
   localparam logic [5:0] SAC_DATA_EDGES = 6'd14;
   localparam logic [5:0] SAC_PWRUP_CAL_EDGES = 6'd16;
   localparam logic [5:0] SAC_CAL_START_EDGE = 6'd17;
   localparam logic [5:0] SAC_CAL_DONE_EDGE = 6'd32;
   localparam logic [5:0] SAC_EDGE_MAX = 6'd63;
   // ---------------------------------------------------------------
   // host timing (host side obligations, kept for reference)
   // ---------------------------------------------------------------
   localparam real SAC_SELECT_TO_CLOCK_SETUP_NS = 15.0;
   localparam real SAC_ACQUISITION_INTERVAL_NS = 200.0;
   localparam real SAC_CLK_MHZ = 10.0;
   localparam int SAC_ACQ_CYCLES = int'($ceil(SAC_ACQUISITION_INTERVAL_NS * SAC_CLK_MHZ / 1000.0));
   // ---------------------------------------------------------------
   // buffering
   // ---------------------------------------------------------------
   localparam int SAC_FIFO_DEPTH = 16;
endpackage

// >>> sac_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module sac_sync
   import sac_pkg::*;
#(
   parameter logic INIT = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // level in and out
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic meta;
      logic sync;
   } sac_sync_s;
   sac_sync_s st_r;
   sac_sync_s st_nxt;
   always_comb begin
      st_nxt.meta = din;
      st_nxt.sync = st_r.meta;
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         st_r <= {INIT, INIT};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign dout = st_r.sync;
endmodule
